// [pkg/eat_pkg.sv]
// Types shared by the translation unit
package eat_pkg;

	typedef enum logic [2:0] {
		EAT_GEN_BASE  = 3'h1,
		EAT_GEN_IMM   = 3'h2,
		EAT_GEN_INDEX = 3'h4
	} eat_gen_e;

	typedef enum logic [2:0] {
		EAT_SRC_MEM    = 3'h1,
		EAT_SRC_BRANCH = 3'h2,
		EAT_SRC_SEQ    = 3'h4
	} eat_src_e;

	typedef struct packed {
		logic        valid;
		eat_src_e    src;
		eat_gen_e    gen;
		logic        store;
		logic [4:0]  base_register_field;
		logic [4:0]  index_register_field;
		logic [31:0] base_value;
		logic [31:0] index_value;
		logic [15:0] offset;
		logic [31:0] pc;
	} eat_req_s;

	typedef struct packed {
		logic        valid;
		logic        fault;
		logic        miss;
		logic        block_hit;
		logic [3:0]  wimg;
		logic [31:0] effective_address;
		logic [51:0] virt_addr;
		logic [31:0] phys_addr;
	} eat_resp_s;

	typedef struct packed {
		logic        valid;
		logic [39:0] vpn;
		logic [19:0] rpn;
		logic [3:0]  wimg;
		logic [1:0]  pp;
	} eat_tlb_s;

endpackage

// [pkg/eat_regs.svh]
// Register offsets, field positions, reset values and entry counts
`ifndef EAT_REGS_SVH
`define EAT_REGS_SVH

`define EAT_SEG_BASE        8'h00
`define EAT_BLK_UPPER_BASE  8'h10
`define EAT_BLK_LOWER_BASE  8'h14
`define EAT_CTRL            8'h18
`define EAT_PTE_WR          8'h1c
`define EAT_PTE_TAG         8'h1d
`define EAT_STATUS          8'h1e
`define EAT_LAST_PA         8'h1f
`define EAT_NUM_SEG         16
`define EAT_NUM_BLK         4
`define EAT_NUM_TLB         8
`define EAT_CTRL_IXLAT      0
`define EAT_CTRL_DXLAT      1
`define EAT_CTRL_SUPER      2
`define EAT_CTRL_RESET      32'h00000000
`define EAT_BLK_VS          1
`define EAT_BLK_VP          0
`define EAT_BLK_BL_LO       2
`define EAT_BLK_BL_HI       12
`define EAT_BLK_PP_LO       0
`define EAT_BLK_WIMG_LO     3
`define EAT_SEG_KS          30
`define EAT_SEG_KP          29
`define EAT_SEG_VSID_LO     0

`endif

// [sim/eat_cpu_model.sv]
// Fetch and load/store front end model
`timescale 1ns/1ps
module eat_cpu_model
	import eat_pkg::*;
(
	// Clock
	input wire logic clk,
	// Request
	output eat_req_s req
);
	initial req = '0;
	// One cycle request, then idle with scrambled fields
	task automatic issue(input eat_req_s r);
		eat_req_s n;
		n = ~r;
		n.valid = 1'b0;
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= n;
	endtask
endmodule

// [sim/eat_mmu_assertions.sv]
// Port checks for the translation unit
`timescale 1ns/1ps
module eat_mmu_assertions
	import eat_pkg::*;
(
	// Clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic        CLK_EN,
	// Register port
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	// Access port
	input wire eat_req_s    REQ,
	input wire eat_resp_s   RESP
);
	logic        mem;
	logic        g_b;
	logic        g_i;
	logic        g_x;
	logic        sq;
	logic        br;
	logic [31:0] be;
	logic [31:0] ie;
	logic [31:0] xe;
	logic [31:0] pe;
	logic [31:0] bre;
	assign mem = !RST && CLK_EN && REQ.valid && (REQ.src == EAT_SRC_MEM);
	assign g_b = mem && (REQ.gen == EAT_GEN_BASE);
	assign g_i = mem && (REQ.gen == EAT_GEN_IMM);
	assign g_x = mem && (REQ.gen == EAT_GEN_INDEX);
	assign sq = !RST && CLK_EN && REQ.valid && (REQ.src == EAT_SRC_SEQ);
	assign be = (REQ.base_register_field == 5'h00) ? 32'h0 : REQ.base_value;
	assign ie = be + {{16{REQ.offset[15]}}, REQ.offset};
	assign xe = be + REQ.index_value;
	assign pe = REQ.pc + 32'h4;
	assign br = !RST && CLK_EN && REQ.valid && (REQ.src == EAT_SRC_BRANCH) &&
		(REQ.gen == EAT_GEN_IMM);
	assign bre = REQ.pc + {{16{REQ.offset[15]}}, REQ.offset};
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////
	chk_resp_follows: assert property (
		!$past(RST) && $past(CLK_EN) |-> RESP.valid == $past(REQ.valid)) else $error("bad valid");
	chk_ea_base: assert property (
		$past(g_b) |-> RESP.effective_address == $past(be)) else $error("bad base form");
	chk_ea_imm: assert property (
		$past(g_i) |-> RESP.effective_address == $past(ie)) else $error("bad offset form");
	chk_ea_index: assert property (
		$past(g_x) |-> RESP.effective_address == $past(xe)) else $error("bad index form");
	chk_ea_seq: assert property (
		$past(sq) |-> RESP.effective_address == $past(pe)) else $error("bad fetch address");
	chk_rdata_one: assert property (
		!$past(RST) && $past(CLK_EN) && !$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside slot");
	chk_block_wins: assert property (
		RESP.valid && RESP.block_hit |-> !RESP.miss &&
		RESP.phys_addr[16:0] == RESP.effective_address[16:0]) else $error("bad block hit");
	chk_ea_branch: assert property (
		$past(br) |-> RESP.effective_address == $past(bre)) else $error("bad branch address");
	chk_page_offset: assert property (
		RESP.valid && !RESP.block_hit && !RESP.miss |->
		RESP.phys_addr[11:0] == RESP.effective_address[11:0]) else $error("bad page offset");
	chk_virt_low: assert property (
		RESP.valid && RESP.miss |-> RESP.virt_addr[27:0] == RESP.effective_address[27:0])
		else $error("bad virtual offset");
endmodule

bind eat_mmu eat_mmu_assertions i_eat_mmu_assertions (.CORE_CLK(CORE_CLK), .RST(RST),
	.CLK_EN(CLK_EN), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ(REQ), .RESP(RESP));

// [sim/eat_mmu_tb.sv]
// Self-checking bench for the translation unit
`timescale 1ns/1ps
module eat_mmu_tb
	import eat_pkg::*;
;
	typedef struct packed {
		eat_gen_e    gen;
		logic [4:0]  ra;
		logic [31:0] b;
		logic [31:0] x;
		logic [15:0] off;
		logic [31:0] ea;
	} eat_row_s;
	logic        CORE_CLK = 0;
	logic        RST = 1;
	logic        CLK_EN = 1;
	logic [7:0]  REG_ADDR = 0;
	logic [31:0] REG_WDATA = 0;
	logic        REG_WR = 0;
	logic        REG_RD = 0;
	logic [31:0] REG_RDATA;
	eat_req_s    req;
	eat_resp_s   RESP;
	int          miscompares = 0;
	int          num_checks = 0;
	eat_row_s    rows [7] = '{
		'{EAT_GEN_BASE, 5'h03, 32'h10000010, 32'h0, 16'h0, 32'h10000010},
		'{EAT_GEN_BASE, 5'h00, 32'hdeadbeef, 32'h0, 16'h0, 32'h0},
		'{EAT_GEN_IMM, 5'h03, 32'h100, 32'h0, 16'h0, 32'h100},
		'{EAT_GEN_IMM, 5'h03, 32'h100, 32'h0, 16'hfff0, 32'hf0},
		'{EAT_GEN_IMM, 5'h00, 32'h555, 32'h0, 16'h20, 32'h20},
		'{EAT_GEN_INDEX, 5'h03, 32'h10, 32'h22, 16'h0, 32'h32},
		'{EAT_GEN_INDEX, 5'h00, 32'h10, 32'h22, 16'h0, 32'h22}};
	always #2 CORE_CLK = ~CORE_CLK;
	eat_cpu_model i_eat_cpu_model (.clk(CORE_CLK), .req(req));
	eat_mmu i_eat_mmu (.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REQ(req), .RESP(RESP));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		chk("REG_RDATA", e, REG_RDATA);
	endtask
	function automatic eat_req_s mk(eat_src_e s, eat_gen_e g, logic st, logic [4:0] ra,
		logic [31:0] b, logic [31:0] x, logic [15:0] off, logic [31:0] pc);
		mk = '{1'b1, s, g, st, ra, 5'h04, b, x, off, pc};
	endfunction
	// Flags are valid, fault, miss, block hit, wimg; wimg ignored on a miss
	task automatic acc(input eat_req_s r, input logic [31:0] ea, input logic [31:0] pa,
		input logic [7:0] fl);
		i_eat_cpu_model.issue(r);
		#1;
		chk("effective_address", ea, RESP.effective_address);
		chk("flags", 32'(fl), 32'({RESP.valid, RESP.fault, RESP.miss, RESP.block_hit,
			fl[5] ? fl[3:0] : RESP.wimg}));
		if (!fl[5]) chk("phys_addr", pa, RESP.phys_addr);
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		#1;
		chk("reset RESP", 32'h0, RESP.phys_addr);
		for (int i = 0; i < 7; i++) begin
			acc(mk(EAT_SRC_MEM, rows[i].gen, 1'b0, rows[i].ra, rows[i].b, rows[i].x, rows[i].off,
				32'h0), rows[i].ea, rows[i].ea, 8'h80);
		end
		acc(mk(EAT_SRC_SEQ, EAT_GEN_BASE, 0, 0, 0, 0, 0, 32'h2000), 32'h2004, 32'h2004, 8'h80);
		acc(mk(EAT_SRC_BRANCH, EAT_GEN_IMM, 0, 0, 0, 0, 16'hfff0, 32'h3000), 32'h2ff0,
			32'h2ff0, 8'h80);
		rd(8'h20, 32'h0);
		wr(8'h10, 32'h12340002);
		rd(8'h10, 32'h0);
		wr(8'h18, 32'h7);
		rd(8'h18, 32'h7);
		wr(8'h10, 32'h12340002);
		wr(8'h14, 32'h80000052);
		rd(8'h14, 32'h80000052);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 0, 1, 32'h12345678, 0, 0, 0), 32'h12345678,
			32'h80005678, 8'h9a);
		acc(mk(EAT_SRC_SEQ, EAT_GEN_BASE, 0, 0, 0, 0, 0, 32'h12345674), 32'h12345678,
			32'h80005678, 8'h9a);
		wr(8'h14, 32'h80000051);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 1, 1, 32'h12345678, 0, 0, 0), 32'h12345678,
			32'h80005678, 8'hda);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 0, 1, 32'h50000000, 0, 0, 0), 32'h50000000, 0,
			8'ha0);
		wr(8'h05, 32'h00000abc);
		wr(8'h1d, 32'h0000abc3);
		wr(8'h1c, 32'h82af3797);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 0, 1, 32'h53000123, 0, 0, 0), 32'h53000123,
			32'habcde123, 8'h85);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 1, 1, 32'h53000123, 0, 0, 0), 32'h53000123,
			32'habcde123, 8'hc5);
		rd(8'h1f, 32'habcde123);
		rd(8'h1e, 32'h00020001);
		rd(8'h1d, 32'h0000abc3);
		wr(8'h18, 32'h4);
		acc(mk(EAT_SRC_MEM, EAT_GEN_BASE, 0, 1, 32'h12345678, 0, 0, 0), 32'h12345678,
			32'h12345678, 8'h80);
		@(posedge CORE_CLK);
		CLK_EN <= 1'b0;
		wr(8'h18, 32'h0);
		CLK_EN <= 1'b1;
		rd(8'h18, 32'h4);
		@(posedge CORE_CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		rd(8'h18, 32'h0);
		wrap_up();
	end
endmodule

// [verilog/eat_ea_gen.sv]
// Effective address adder for all three addressing forms
`timescale 1ns/1ps
module eat_ea_gen
	import eat_pkg::*;
(
	// Request
	input  wire eat_req_s    req,
	// Result
	output logic [31:0]      effective_address
);
	logic [31:0] base;
	logic [31:0] addend;

	always_comb begin
		base = (req.base_register_field == 5'h00) ? 32'h00000000 : req.base_value; // RULE2
		case (req.gen) // RULE1
			EAT_GEN_BASE:  addend = 32'h00000000;
			EAT_GEN_IMM:   addend = {{16{req.offset[15]}}, req.offset};
			EAT_GEN_INDEX: addend = req.index_value;
			default:       addend = 32'h00000000;
		endcase
		case (req.src) // RULE3
			EAT_SRC_MEM:    effective_address = base + addend;
			EAT_SRC_BRANCH: effective_address = req.pc + addend;
			EAT_SRC_SEQ:    effective_address = req.pc + 32'h00000004;
			default:        effective_address = base + addend;
		endcase
	end
endmodule

// [verilog/eat_mmu.sv]
// Effective address translation unit: segments, block array and page lookaside buffer
//
// Overview of operation
// RULE1 - Memory accesses form addresses from base alone, base plus immediate, or base plus index.
// RULE2 - A base register field of zero uses the constant zero instead of the register.
// RULE3 - An effective address is made for memory access, branch and sequential fetch.
// RULE4 - Translation maps effective to physical only while enabled, otherwise passes through.
// RULE5 - Instruction fetches and load/store data accesses are both translated.
// RULE6 - Sixteen segment registers each cover one 256 Mbyte segment picked by the top nibble.
// RULE7 - A 52-bit virtual address is formed and a 32-bit physical address produced.
// RULE8 - Segment contents give the virtual address and page entries give the physical one.
// RULE9 - Block entries map regions from 128 Kbyte to 256 Mbyte chosen by a length mask.
// RULE10 - Each block entry is a register pair writable only at supervisor level.
// RULE11 - Each page or block supplies write-through, inhibit, coherent and guarded bits.
// RULE12 - Every translated access is checked against the page or block protection.
// RULE13 - Recent page entries are kept in an on-chip lookaside buffer.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "eat_regs.svh"
module eat_mmu
	import eat_pkg::*;
(
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        CLK_EN,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [31:0]      REG_RDATA,
	// Access request
	input  wire eat_req_s    REQ,
	// Translation result
	output eat_resp_s        RESP
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [`EAT_NUM_SEG-1:0][31:0] seg;
		logic [`EAT_NUM_BLK-1:0][31:0] blk_upper;
		logic [`EAT_NUM_BLK-1:0][31:0] blk_lower;
		logic [31:0]                   ctrl;
		logic [39:0]                   pte_tag;
		logic [`EAT_NUM_TLB-1:0]       tlb_valid;
		logic [`EAT_NUM_TLB-1:0][39:0] tlb_vpn;
		logic [`EAT_NUM_TLB-1:0][19:0] tlb_rpn;
		logic [`EAT_NUM_TLB-1:0][3:0]  tlb_wimg;
		logic [`EAT_NUM_TLB-1:0][1:0]  tlb_pp;
		logic [2:0]                    tlb_ptr;
		logic [31:0]                   rdata;
		logic [15:0]                   fault_cnt;
		logic [15:0]                   miss_cnt;
		logic [31:0]                   last_pa;
		eat_resp_s                     resp;
	} eat_state_s;

	eat_state_s  r;
	eat_state_s  next_r;
	logic [31:0] effective_address;

	////////////////////////////////////////////////////////////////////////
	eat_ea_gen u_ea_gen ( // RULE1 RULE2 RULE3
		.req               (REQ),
		.effective_address (effective_address)
	);

	// Protection check from key and two-bit setting
	function automatic logic prot_ok(input logic key, input logic [1:0] pp, input logic store);
		if (!key)
			prot_ok = !(store && pp == 2'h3);
		else
			prot_ok = (pp != 2'h0) && !(store && pp != 2'h2);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [`EAT_NUM_BLK-1:0] blk_match;
	logic [`EAT_NUM_TLB-1:0] tlb_match;

	genvar g;
	generate
		for (g = 0; g < `EAT_NUM_BLK; g++) begin : g_blk
			logic [10:0] bl;
			logic        valid_mode;
			assign bl = r.blk_upper[g][`EAT_BLK_BL_HI:`EAT_BLK_BL_LO];
			assign valid_mode = r.ctrl[`EAT_CTRL_SUPER] ? r.blk_upper[g][`EAT_BLK_VS]
			                                            : r.blk_upper[g][`EAT_BLK_VP];
			// Upper bits compared except where the length mask widens the block
			assign blk_match[g] = valid_mode &&
				((effective_address[31:17] & ~{4'h0, bl}) ==
				 (r.blk_upper[g][31:17] & ~{4'h0, bl})); // RULE9
		end
	endgenerate

	logic [3:0]  seg_idx;
	logic [31:0] seg_reg;
	logic [51:0] virt_addr;
	logic        xlat_on;

	assign seg_idx = effective_address[31:28];
	assign seg_reg = r.seg[seg_idx]; // RULE6
	assign virt_addr = {seg_reg[23:0], effective_address[27:0]}; // RULE7 RULE8

	generate
		for (g = 0; g < `EAT_NUM_TLB; g++) begin : g_tlb
			assign tlb_match[g] = r.tlb_valid[g] && (r.tlb_vpn[g] == virt_addr[51:12]); // RULE13
		end
	endgenerate

	// Separate enables for fetch and data accesses
	assign xlat_on = (REQ.src == EAT_SRC_MEM) ? r.ctrl[`EAT_CTRL_DXLAT]
	                                          : r.ctrl[`EAT_CTRL_IXLAT]; // RULE5

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [31:0] blk_pa;
		logic [3:0]  blk_wimg;
		logic [1:0]  blk_pp;
		logic [19:0] tlb_pa;
		logic [3:0]  tlb_wimg;
		logic [1:0]  tlb_pp;
		logic        key;
		logic [10:0] bl;
		blk_pa   = 32'h00000000;
		blk_wimg = 4'h0;
		blk_pp   = 2'h0;
		tlb_pa   = 20'h00000;
		tlb_wimg = 4'h0;
		tlb_pp   = 2'h0;
		key      = 1'b0;
		bl       = 11'h000;
		next_r   = r;

		for (int i = `EAT_NUM_BLK - 1; i >= 0; i--) begin
			if (blk_match[i]) begin
				bl = r.blk_upper[i][`EAT_BLK_BL_HI:`EAT_BLK_BL_LO];
				blk_pa = {(r.blk_lower[i][31:17] & ~{4'h0, bl}) |
				          (effective_address[31:17] & {4'h0, bl}),
				          effective_address[16:0]};
				blk_wimg = r.blk_lower[i][`EAT_BLK_WIMG_LO +: 4]; // RULE11
				blk_pp = r.blk_lower[i][`EAT_BLK_PP_LO +: 2];
			end
		end
		for (int i = 0; i < `EAT_NUM_TLB; i++) begin
			if (tlb_match[i]) begin
				tlb_pa = r.tlb_rpn[i];
				tlb_wimg = r.tlb_wimg[i]; // RULE11
				tlb_pp = r.tlb_pp[i];
			end
		end
		key = r.ctrl[`EAT_CTRL_SUPER] ? seg_reg[`EAT_SEG_KS] : seg_reg[`EAT_SEG_KP];

		// Translation result
		next_r.resp.valid = REQ.valid;
		next_r.resp.effective_address = effective_address;
		next_r.resp.virt_addr = virt_addr;
		next_r.resp.fault = 1'b0;
		next_r.resp.miss = 1'b0;
		next_r.resp.block_hit = 1'b0;
		if (!xlat_on) begin
			next_r.resp.phys_addr = effective_address; // RULE4
			next_r.resp.wimg = 4'h0;
		end else if (|blk_match) begin
			next_r.resp.block_hit = 1'b1;
			next_r.resp.phys_addr = blk_pa;
			next_r.resp.wimg = blk_wimg;
			next_r.resp.fault = REQ.store && (blk_pp == 2'h1 || blk_pp == 2'h0); // RULE12
			if (blk_pp == 2'h0)
				next_r.resp.fault = 1'b1; // RULE12
		end else if (|tlb_match) begin
			next_r.resp.phys_addr = {tlb_pa, effective_address[11:0]}; // RULE4 RULE8
			next_r.resp.wimg = tlb_wimg;
			next_r.resp.fault = !prot_ok(key, tlb_pp, REQ.store); // RULE12
		end else begin
			next_r.resp.phys_addr = 32'h00000000;
			next_r.resp.wimg = 4'h0;
			next_r.resp.miss = 1'b1;
		end
		if (!REQ.valid) begin
			next_r.resp.fault = 1'b0;
			next_r.resp.miss = 1'b0;
		end
		if (REQ.valid && next_r.resp.fault)
			next_r.fault_cnt = r.fault_cnt + 16'h0001;
		if (REQ.valid && next_r.resp.miss)
			next_r.miss_cnt = r.miss_cnt + 16'h0001;
		if (REQ.valid)
			next_r.last_pa = next_r.resp.phys_addr;

		// Register writes
		if (REG_WR) begin
			if (REG_ADDR < `EAT_BLK_UPPER_BASE)
				next_r.seg[REG_ADDR[3:0]] = REG_WDATA; // RULE6
			else if (REG_ADDR < `EAT_BLK_LOWER_BASE) begin
				if (r.ctrl[`EAT_CTRL_SUPER])
					next_r.blk_upper[REG_ADDR[1:0]] = REG_WDATA; // RULE10
			end else if (REG_ADDR < `EAT_CTRL) begin
				if (r.ctrl[`EAT_CTRL_SUPER])
					next_r.blk_lower[REG_ADDR[1:0]] = REG_WDATA; // RULE10
			end else if (REG_ADDR == `EAT_CTRL)
				next_r.ctrl = REG_WDATA & 32'h00000007;
			else if (REG_ADDR == `EAT_PTE_TAG)
				next_r.pte_tag = {REG_WDATA[27:0], 12'h000};
			else if (REG_ADDR == `EAT_PTE_WR) begin
				// Drop older copies of the page so a lookup never hits twice
				for (int i = 0; i < `EAT_NUM_TLB; i++) begin
					if (r.tlb_vpn[i] == r.pte_tag)
						next_r.tlb_valid[i] = 1'b0; // RULE13
				end
				// Refill one lookaside entry round robin
				next_r.tlb_valid[r.tlb_ptr] = REG_WDATA[31];
				next_r.tlb_vpn[r.tlb_ptr] = r.pte_tag;
				next_r.tlb_rpn[r.tlb_ptr] = REG_WDATA[25:6];
				next_r.tlb_wimg[r.tlb_ptr] = REG_WDATA[5:2];
				next_r.tlb_pp[r.tlb_ptr] = REG_WDATA[1:0];
				next_r.tlb_ptr = r.tlb_ptr + 3'h1; // RULE13
			end
		end

		// Register reads
		next_r.rdata = 32'h00000000;
		if (REG_RD) begin
			if (REG_ADDR < `EAT_BLK_UPPER_BASE)
				next_r.rdata = r.seg[REG_ADDR[3:0]];
			else if (REG_ADDR < `EAT_BLK_LOWER_BASE)
				next_r.rdata = r.ctrl[`EAT_CTRL_SUPER] ? r.blk_upper[REG_ADDR[1:0]] : 32'h0; // RULE10
			else if (REG_ADDR < `EAT_CTRL)
				next_r.rdata = r.ctrl[`EAT_CTRL_SUPER] ? r.blk_lower[REG_ADDR[1:0]] : 32'h0; // RULE10
			else if (REG_ADDR == `EAT_CTRL)
				next_r.rdata = r.ctrl;
			else if (REG_ADDR == `EAT_PTE_TAG)
				next_r.rdata = {4'h0, r.pte_tag[39:12]};
			else if (REG_ADDR == `EAT_STATUS)
				next_r.rdata = {r.fault_cnt, r.miss_cnt};
			else if (REG_ADDR == `EAT_LAST_PA)
				next_r.rdata = r.last_pa;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			r <= '0;
			r.ctrl <= `EAT_CTRL_RESET;
		end else if (CLK_EN) begin
			r <= next_r;
		end
	end

	assign REG_RDATA = r.rdata;
	assign RESP = r.resp;
endmodule
